// file: crs_params.svh
// Constants for the core register set: field positions, reset values, stack layout
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

`define CRS_CC_C 0
`define CRS_CC_Z 1
`define CRS_CC_N 2
`define CRS_CC_I0 3
`define CRS_CC_H 4
`define CRS_CC_I1 5
`define CRS_CC_RESET 8'he8
`define CRS_CC_FIXED_MASK 8'hc0

`define CRS_MASK_LEVEL0 2'h2
`define CRS_MASK_LEVEL3 2'h3

`define CRS_SP_PAGE 8'h01
`define CRS_SP_LOW_RESET 8'h7f
`define CRS_SP_RESET 16'h017f

`define CRS_VEC_HIGH_ADDR 16'hfffe
`define CRS_VEC_LOW_ADDR 16'hffff

`define CRS_INT_STACK_BYTES 3'h5
`define CRS_CALL_STACK_BYTES 3'h2
`define CRS_VEC_BYTES 3'h2
`define CRS_ONE_BYTE 3'h1

`define CRS_FLASH_CTRL_RESET 8'h00

`endif

// file: crs_pkg.sv
// Types shared by the core register set and its flag unit
package crs_pkg;

  typedef enum logic [4:0] {
    CMD_NOP,
    CMD_ALU,
    CMD_LOAD,
    CMD_LOAD_SPL,
    CMD_PC_SET,
    CMD_PC_INC,
    CMD_SCF,
    CMD_RCF,
    CMD_CARRY,
    CMD_SIM,
    CMD_RIM,
    CMD_HALT,
    CMD_WFI,
    CMD_RSP,
    CMD_PUSH,
    CMD_POP,
    CMD_CALL,
    CMD_RET,
    CMD_INT,
    CMD_INTERRUPT_RETURN_INSTR,
    CMD_FLASH_WR
  } crs_cmd_t;

  typedef enum logic [3:0] {
    ALU_ADD,
    ALU_ADC,
    ALU_SUB,
    ALU_SBC,
    ALU_AND,
    ALU_OR,
    ALU_XOR,
    ALU_PASS,
    ALU_SLL,
    ALU_SRL,
    ALU_RLC,
    ALU_RRC
  } crs_alu_t;

  typedef enum logic [2:0] {
    SLOT_A,
    SLOT_X,
    SLOT_Y,
    SLOT_CC,
    SLOT_PCL,
    SLOT_PCH
  } crs_slot_t;

  typedef enum logic [1:0] {
    SEQ_ONE,
    SEQ_INT,
    SEQ_CALL,
    SEQ_VEC
  } crs_seq_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PUSH,
    ST_POP,
    ST_DRAIN
  } crs_state_t;

endpackage

// file: crs_alu_flags.sv
// Arithmetic and logic unit with carry and half-carry generation
`timescale 1ns/10ps
`default_nettype none

module crs_alu_flags (
  input wire crs_pkg::crs_alu_t op,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  output logic [7:0] result,
  output logic carryOut,
  output logic halfOut,
  output logic carryValid,
  output logic halfValid
);

  logic [8:0] wide;
  logic [4:0] nibble;
  logic cin;

  always_comb begin
    cin = (op == crs_pkg::ALU_ADC || op == crs_pkg::ALU_SBC) ? carryIn : 1'b0;
    wide = 9'h000;
    nibble = 5'h00;
    result = 8'h00;
    carryOut = 1'b0;
    halfOut = 1'b0;
    carryValid = 1'b0;
    halfValid = 1'b0;
    case (op)
      crs_pkg::ALU_ADD, crs_pkg::ALU_ADC: begin
        wide = {1'b0, opA} + {1'b0, opB} + {8'h00, cin};
        nibble = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, cin};
        result = wide[7:0];
        carryOut = wide[8];
        halfOut = nibble[4];
        carryValid = 1'b1;
        halfValid = 1'b1;
      end
      crs_pkg::ALU_SUB, crs_pkg::ALU_SBC: begin
        // Borrow shows as the ninth bit of the difference
        wide = {1'b0, opA} - {1'b0, opB} - {8'h00, cin};
        result = wide[7:0];
        carryOut = wide[8];
        carryValid = 1'b1;
      end
      crs_pkg::ALU_AND: result = opA & opB;
      crs_pkg::ALU_OR: result = opA | opB;
      crs_pkg::ALU_XOR: result = opA ^ opB;
      crs_pkg::ALU_PASS: result = opB;
      crs_pkg::ALU_SLL, crs_pkg::ALU_RLC: begin
        result = {opA[6:0], (op == crs_pkg::ALU_RLC) ? carryIn : 1'b0};
        carryOut = opA[7];
        carryValid = 1'b1;
      end
      crs_pkg::ALU_SRL, crs_pkg::ALU_RRC: begin
        result = {(op == crs_pkg::ALU_RRC) ? carryIn : 1'b0, opA[7:1]};
        carryOut = opA[0];
        carryValid = 1'b1;
      end
      default: result = opA;
    endcase
  end

endmodule

`default_nettype wire

// file: cpu_core_register_set.sv
// Core register set: accumulator, index pair, program counter, flags, stack pointer
`timescale 1ns/10ps
`default_nettype none
`include "crs_params.svh"

module cpu_core_register_set (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire crs_pkg::crs_cmd_t cmdCode,
  input wire crs_pkg::crs_alu_t cmdAluOp,
  input wire crs_pkg::crs_slot_t cmdReg,
  input wire logic [7:0] cmdData,
  input wire logic [15:0] cmdAddr,
  input wire logic [1:0] cmdPriority,
  input wire logic [7:0] memRdData,
  output logic busy,
  output logic [15:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWrite,
  output logic memRead,
  output logic [7:0] accumulator,
  output logic [7:0] indexFirst,
  output logic [7:0] indexSecond,
  output logic [15:0] programCounter,
  output logic [7:0] conditionFlags,
  output logic [15:0] stackPointer,
  output logic [7:0] flashProgramControl
);

  crs_pkg::crs_state_t state;
  crs_pkg::crs_seq_t seqKind;
  crs_pkg::crs_slot_t seqSingle;
  logic [2:0] seqIdx;
  logic [15:0] seqTarget;
  logic [1:0] seqPriority;
  logic [7:0] spLow;
  logic rdPend;
  crs_pkg::crs_slot_t rdSlot;
  crs_pkg::crs_slot_t rdSlotIssue;
  crs_pkg::crs_slot_t curSlot;
  logic [7:0] pushValue;
  logic [7:0] aluIn;
  logic [7:0] aluResult;
  logic aluCarry;
  logic aluHalf;
  logic aluCarryValid;
  logic aluHalfValid;
  logic take;
  logic pushLast;
  logic popLast;
  logic [7:0] next_spUp;

  function automatic logic [2:0] seqLen(input crs_pkg::crs_seq_t kind);
    case (kind)
      crs_pkg::SEQ_INT: seqLen = `CRS_INT_STACK_BYTES;
      crs_pkg::SEQ_CALL: seqLen = `CRS_CALL_STACK_BYTES;
      crs_pkg::SEQ_VEC: seqLen = `CRS_VEC_BYTES;
      default: seqLen = `CRS_ONE_BYTE;
    endcase
  endfunction

  // Pop order is the push order reversed, so one table serves both
  function automatic crs_pkg::crs_slot_t slotAt(
    input crs_pkg::crs_seq_t kind,
    input logic [2:0] idx,
    input logic pop,
    input crs_pkg::crs_slot_t single
  );
    logic [2:0] k;
    k = pop ? (seqLen(kind) - 3'h1 - idx) : idx;
    slotAt = single;
    case (kind)
      crs_pkg::SEQ_INT: begin
        // Second index deliberately absent from the context frame
        case (k)
          3'h0: slotAt = crs_pkg::SLOT_PCL;
          3'h1: slotAt = crs_pkg::SLOT_PCH;
          3'h2: slotAt = crs_pkg::SLOT_X;
          3'h3: slotAt = crs_pkg::SLOT_A;
          default: slotAt = crs_pkg::SLOT_CC;
        endcase
      end
      crs_pkg::SEQ_CALL: slotAt = (k == 3'h0) ? crs_pkg::SLOT_PCL : crs_pkg::SLOT_PCH;
      crs_pkg::SEQ_VEC: slotAt = (idx == 3'h0) ? crs_pkg::SLOT_PCH : crs_pkg::SLOT_PCL;
      default: slotAt = single;
    endcase
  endfunction

  crs_alu_flags u_alu (
    .op(cmdAluOp),
    .opA(aluIn),
    .opB(cmdData),
    .carryIn(conditionFlags[`CRS_CC_C]),
    .result(aluResult),
    .carryOut(aluCarry),
    .halfOut(aluHalf),
    .carryValid(aluCarryValid),
    .halfValid(aluHalfValid)
  );

  assign take = cmdValid && (state == crs_pkg::ST_IDLE);
  assign pushLast = (state == crs_pkg::ST_PUSH) && (seqIdx == seqLen(seqKind) - 3'h1);
  assign popLast = (state == crs_pkg::ST_POP) && (seqIdx == seqLen(seqKind) - 3'h1);
  assign curSlot = slotAt(seqKind, seqIdx, state == crs_pkg::ST_POP, seqSingle);
  assign next_spUp = spLow + 8'h01;

  always_comb begin
    case (cmdReg)
      crs_pkg::SLOT_X: aluIn = indexFirst;
      crs_pkg::SLOT_Y: aluIn = indexSecond;
      default: aluIn = accumulator;
    endcase
  end

  always_comb begin
    case (curSlot)
      crs_pkg::SLOT_A: pushValue = accumulator;
      crs_pkg::SLOT_X: pushValue = indexFirst;
      crs_pkg::SLOT_Y: pushValue = indexSecond;
      crs_pkg::SLOT_CC: pushValue = conditionFlags;
      crs_pkg::SLOT_PCL: pushValue = programCounter[7:0];
      default: pushValue = programCounter[15:8];
    endcase
  end

  // Sequencer; reset starts straight into the vector fetch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= crs_pkg::ST_POP;
      seqKind <= crs_pkg::SEQ_VEC;
      seqSingle <= crs_pkg::SLOT_A;
      seqIdx <= 3'h0;
      seqTarget <= 16'h0000;
      seqPriority <= `CRS_MASK_LEVEL3;
      busy <= 1'b1;
    end else begin
      case (state)
        crs_pkg::ST_IDLE: begin
          seqIdx <= 3'h0;
          seqSingle <= cmdReg;
          seqTarget <= cmdAddr;
          seqPriority <= cmdPriority;
          if (take) begin
            case (cmdCode)
              crs_pkg::CMD_PUSH: begin
                seqKind <= crs_pkg::SEQ_ONE;
                state <= crs_pkg::ST_PUSH;
                busy <= 1'b1;
              end
              crs_pkg::CMD_POP: begin
                seqKind <= crs_pkg::SEQ_ONE;
                state <= crs_pkg::ST_POP;
                busy <= 1'b1;
              end
              crs_pkg::CMD_CALL: begin
                seqKind <= crs_pkg::SEQ_CALL;
                state <= crs_pkg::ST_PUSH;
                busy <= 1'b1;
              end
              crs_pkg::CMD_RET: begin
                seqKind <= crs_pkg::SEQ_CALL;
                state <= crs_pkg::ST_POP;
                busy <= 1'b1;
              end
              crs_pkg::CMD_INT: begin
                seqKind <= crs_pkg::SEQ_INT;
                state <= crs_pkg::ST_PUSH;
                busy <= 1'b1;
              end
              crs_pkg::CMD_INTERRUPT_RETURN_INSTR: begin
                seqKind <= crs_pkg::SEQ_INT;
                state <= crs_pkg::ST_POP;
                busy <= 1'b1;
              end
              default: state <= crs_pkg::ST_IDLE;
            endcase
          end
        end
        crs_pkg::ST_PUSH: begin
          seqIdx <= seqIdx + 3'h1;
          if (pushLast) begin
            state <= crs_pkg::ST_IDLE;
            busy <= 1'b0;
          end
        end
        crs_pkg::ST_POP: begin
          seqIdx <= seqIdx + 3'h1;
          if (popLast) begin
            state <= crs_pkg::ST_DRAIN;
          end
        end
        crs_pkg::ST_DRAIN: begin
          // Hold until the last read byte has been captured
          if (!memRead && !rdPend) begin
            state <= crs_pkg::ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= crs_pkg::ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // Memory port; read data is expected one cycle after memRead
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memAddr <= 16'h0000;
      memWrData <= 8'h00;
      memWrite <= 1'b0;
      memRead <= 1'b0;
      rdPend <= 1'b0;
      rdSlot <= crs_pkg::SLOT_A;
      rdSlotIssue <= crs_pkg::SLOT_A;
    end else begin
      memWrite <= 1'b0;
      memRead <= 1'b0;
      rdPend <= memRead;
      // Slot follows the data, which trails the issue by one cycle
      rdSlot <= rdSlotIssue;
      if (state == crs_pkg::ST_PUSH) begin
        memAddr <= {`CRS_SP_PAGE, spLow};
        memWrData <= pushValue;
        memWrite <= 1'b1;
      end else if (state == crs_pkg::ST_POP) begin
        if (seqKind == crs_pkg::SEQ_VEC) begin
          memAddr <= (seqIdx == 3'h0) ? `CRS_VEC_HIGH_ADDR : `CRS_VEC_LOW_ADDR;
        end else begin
          memAddr <= {`CRS_SP_PAGE, next_spUp};
        end
        memRead <= 1'b1;
        rdSlotIssue <= curSlot;
      end
    end
  end

  // Stack pointer low byte; the page byte is a constant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spLow <= `CRS_SP_LOW_RESET;
    end else if (state == crs_pkg::ST_PUSH) begin
      spLow <= spLow - 8'h01;
    end else if (state == crs_pkg::ST_POP && seqKind != crs_pkg::SEQ_VEC) begin
      spLow <= next_spUp;
    end else if (take && cmdCode == crs_pkg::CMD_RSP) begin
      spLow <= `CRS_SP_LOW_RESET;
    end else if (take && cmdCode == crs_pkg::CMD_LOAD_SPL) begin
      spLow <= cmdData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stackPointer <= `CRS_SP_RESET;
    end else if (state == crs_pkg::ST_PUSH) begin
      stackPointer <= {`CRS_SP_PAGE, spLow - 8'h01};
    end else if (state == crs_pkg::ST_POP && seqKind != crs_pkg::SEQ_VEC) begin
      stackPointer <= {`CRS_SP_PAGE, next_spUp};
    end else if (take && cmdCode == crs_pkg::CMD_RSP) begin
      stackPointer <= {`CRS_SP_PAGE, `CRS_SP_LOW_RESET};
    end else if (take && cmdCode == crs_pkg::CMD_LOAD_SPL) begin
      stackPointer <= {`CRS_SP_PAGE, cmdData};
    end
  end

  // Data registers; none of them has a memory address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator <= 8'h00;
      indexFirst <= 8'h00;
      indexSecond <= 8'h00;
    end else if (rdPend) begin
      case (rdSlot)
        crs_pkg::SLOT_A: accumulator <= memRdData;
        crs_pkg::SLOT_X: indexFirst <= memRdData;
        crs_pkg::SLOT_Y: indexSecond <= memRdData;
        default: accumulator <= accumulator;
      endcase
    end else if (take && (cmdCode == crs_pkg::CMD_ALU || cmdCode == crs_pkg::CMD_LOAD)) begin
      case (cmdReg)
        crs_pkg::SLOT_X: indexFirst <= (cmdCode == crs_pkg::CMD_ALU) ? aluResult : cmdData;
        crs_pkg::SLOT_Y: indexSecond <= (cmdCode == crs_pkg::CMD_ALU) ? aluResult : cmdData;
        crs_pkg::SLOT_CC: accumulator <= accumulator;
        default: accumulator <= (cmdCode == crs_pkg::CMD_ALU) ? aluResult : cmdData;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      programCounter <= 16'h0000;
    end else if (rdPend && rdSlot == crs_pkg::SLOT_PCL) begin
      programCounter[7:0] <= memRdData;
    end else if (rdPend && rdSlot == crs_pkg::SLOT_PCH) begin
      programCounter[15:8] <= memRdData;
    end else if (pushLast && seqKind != crs_pkg::SEQ_ONE) begin
      programCounter <= seqTarget;
    end else if (take && cmdCode == crs_pkg::CMD_PC_SET) begin
      programCounter <= cmdAddr;
    end else if (take && cmdCode == crs_pkg::CMD_PC_INC) begin
      programCounter <= programCounter + 16'h0001;
    end
  end

  // Flags change on the same edge as the result, so the next command sees them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conditionFlags <= `CRS_CC_RESET;
    end else if (rdPend && rdSlot == crs_pkg::SLOT_CC) begin
      conditionFlags <= memRdData | `CRS_CC_FIXED_MASK;
    end else if (pushLast && seqKind == crs_pkg::SEQ_INT) begin
      conditionFlags[`CRS_CC_I1] <= seqPriority[1];
      conditionFlags[`CRS_CC_I0] <= seqPriority[0];
    end else if (take) begin
      case (cmdCode)
        crs_pkg::CMD_ALU: begin
          conditionFlags[`CRS_CC_N] <= aluResult[7];
          conditionFlags[`CRS_CC_Z] <= (aluResult == 8'h00);
          if (aluCarryValid) begin
            conditionFlags[`CRS_CC_C] <= aluCarry;
          end
          if (aluHalfValid) begin
            conditionFlags[`CRS_CC_H] <= aluHalf;
          end
        end
        crs_pkg::CMD_LOAD: begin
          if (cmdReg != crs_pkg::SLOT_CC) begin
            conditionFlags[`CRS_CC_N] <= cmdData[7];
            conditionFlags[`CRS_CC_Z] <= (cmdData == 8'h00);
          end else begin
            conditionFlags <= cmdData | `CRS_CC_FIXED_MASK;
          end
        end
        crs_pkg::CMD_SCF: conditionFlags[`CRS_CC_C] <= 1'b1;
        crs_pkg::CMD_RCF: conditionFlags[`CRS_CC_C] <= 1'b0;
        crs_pkg::CMD_CARRY: conditionFlags[`CRS_CC_C] <= cmdData[0];
        crs_pkg::CMD_SIM: begin
          conditionFlags[`CRS_CC_I1] <= 1'(`CRS_MASK_LEVEL3 >> 1);
          conditionFlags[`CRS_CC_I0] <= 1'b1;
        end
        crs_pkg::CMD_RIM, crs_pkg::CMD_HALT, crs_pkg::CMD_WFI: begin
          conditionFlags[`CRS_CC_I1] <= 1'(`CRS_MASK_LEVEL0 >> 1);
          conditionFlags[`CRS_CC_I0] <= 1'b0;
        end
        default: conditionFlags <= conditionFlags;
      endcase
    end
  end

  // Reserved programming control byte, stored only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flashProgramControl <= `CRS_FLASH_CTRL_RESET;
    end else if (take && cmdCode == crs_pkg::CMD_FLASH_WR) begin
      flashProgramControl <= cmdData;
    end
  end

endmodule

`default_nettype wire

// file: crs_core_asserts.sv
// Concurrent checks on the core register set ports
`timescale 1ns/10ps
`default_nettype none
module crs_core_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire crs_pkg::crs_cmd_t cmdCode,
  input wire crs_pkg::crs_slot_t cmdReg,
  input wire logic [1:0] cmdPriority,
  input wire logic busy,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData,
  input wire logic memWrite,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] indexSecond,
  input wire logic [15:0] programCounter,
  input wire logic [7:0] conditionFlags,
  input wire logic [15:0] stackPointer
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = cmdValid && !busy;

  chk_sp_page: assert property (stackPointer[15:8] == 8'h01)
    else $error("stack pointer left its page");
  chk_cc_fixed: assert property (conditionFlags[7:6] == 2'b11)
    else $error("flag bits 7:6 not one");
  chk_rsp_top: assert property (take && cmdCode == crs_pkg::CMD_RSP |=> stackPointer == 16'h017f)
    else $error("stack reinit missed top");
  chk_carry_set: assert property (take && cmdCode == crs_pkg::CMD_SCF |=> conditionFlags[0])
    else $error("set carry failed");
  chk_mask_set: assert property (take && cmdCode == crs_pkg::CMD_SIM |=> conditionFlags[5] && conditionFlags[3])
    else $error("mask set failed");
  chk_nz_flags: assert property (take && cmdCode == crs_pkg::CMD_ALU && cmdReg == crs_pkg::SLOT_A
    |=> conditionFlags[2] == accumulator[7] && conditionFlags[1] == (accumulator == 8'h00))
    else $error("sign or zero flag wrong");
  chk_int_first: assert property (take && cmdCode == crs_pkg::CMD_INT |-> ##2 memWrite
    && memAddr == $past(stackPointer, 2) && memWrData == 8'($past(programCounter, 2)))
    else $error("first interrupt byte wrong");
  chk_int_busy: assert property (take && cmdCode == crs_pkg::CMD_INT |=> busy [*5] ##1 !busy)
    else $error("interrupt entry length wrong");
  chk_int_sp: assert property (take && cmdCode == crs_pkg::CMD_INT
    |-> ##6 8'(stackPointer - $past(stackPointer, 6)) == 8'hfb)
    else $error("interrupt frame size wrong");
  chk_int_mask: assert property (take && cmdCode == crs_pkg::CMD_INT
    |-> ##6 {conditionFlags[5], conditionFlags[3]} == $past(cmdPriority, 6))
    else $error("interrupt mask not loaded");
  chk_call_sp: assert property (take && cmdCode == crs_pkg::CMD_CALL
    |-> ##3 8'(stackPointer - $past(stackPointer, 3)) == 8'hfe)
    else $error("call frame size wrong");
  chk_y_kept: assert property (take && (cmdCode == crs_pkg::CMD_INT || cmdCode == crs_pkg::CMD_INTERRUPT_RETURN_INSTR)
    |=> $stable(indexSecond) [*5])
    else $error("second index touched by context");
endmodule

bind cpu_core_register_set crs_core_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdReg(cmdReg),
  .cmdPriority(cmdPriority), .busy(busy), .memAddr(memAddr), .memWrData(memWrData),
  .memWrite(memWrite), .accumulator(accumulator), .indexSecond(indexSecond),
  .programCounter(programCounter), .conditionFlags(conditionFlags), .stackPointer(stackPointer)
);
`default_nettype wire

// file: crs_mem_model.sv
// Memory and reset vector model on the far side of the register set
`timescale 1ns/10ps
`default_nettype none
module crs_mem_model #(
  parameter logic [15:0] RESET_VECTOR = 16'h8000
) (
  input wire logic clk,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWrData,
  input wire logic memWrite,
  input wire logic memRead,
  output logic [7:0] memRdData
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i);
    end
    mem[16'hfffe] = RESET_VECTOR[15:8];
    mem[16'hffff] = RESET_VECTOR[7:0];
    memRdData = 8'h00;
  end
  // Data one cycle late; toggles otherwise so a stale byte never passes
  always @(posedge clk) begin
    if (memWrite) begin
      mem[memAddr] <= memWrData;
    end
    memRdData <= memRead ? mem[memAddr] : ~memRdData;
  end
endmodule
`default_nettype wire

// file: cpu_core_register_set_bench.sv
// Directed command sequences for the core register set
`timescale 1ns/10ps
`default_nettype none
module cpu_core_register_set_bench;
  localparam logic [15:0] VEC = 16'h8421;
  localparam crs_pkg::crs_alu_t OPS [6] = '{crs_pkg::ALU_ADD, crs_pkg::ALU_ADD,
    crs_pkg::ALU_ADC, crs_pkg::ALU_SUB, crs_pkg::ALU_AND, crs_pkg::ALU_XOR};
  localparam logic [7:0] DS [6] = '{8'h01, 8'hf0, 8'h01, 8'h03, 8'h0f, 8'h0f};
  localparam logic [7:0] EA [6] = '{8'h10, 8'h00, 8'h02, 8'hff, 8'h0f, 8'h00};
  localparam logic [3:0] EF [6] = '{4'h8, 4'h3, 4'h0, 4'h5, 4'h1, 4'h3};
  localparam crs_pkg::crs_cmd_t CC_OPS [4] = '{crs_pkg::CMD_SCF, crs_pkg::CMD_RCF,
    crs_pkg::CMD_CARRY, crs_pkg::CMD_CARRY};
  localparam crs_pkg::crs_cmd_t MK_OPS [6] = '{crs_pkg::CMD_SIM, crs_pkg::CMD_RIM,
    crs_pkg::CMD_SIM, crs_pkg::CMD_HALT, crs_pkg::CMD_SIM, crs_pkg::CMD_WFI};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  crs_pkg::crs_cmd_t cmdCode = crs_pkg::CMD_NOP;
  crs_pkg::crs_alu_t cmdAluOp = crs_pkg::ALU_ADD;
  crs_pkg::crs_slot_t cmdReg = crs_pkg::SLOT_A;
  logic [7:0] cmdData = 8'h00;
  logic [15:0] cmdAddr = 16'h0000;
  logic [1:0] cmdPriority = 2'h0;
  logic [7:0] memRdData, memWrData, accumulator, indexFirst, indexSecond;
  logic [7:0] conditionFlags, flashProgramControl, cc0;
  logic [15:0] memAddr, programCounter, stackPointer;
  logic busy, memWrite, memRead;
  logic [7:0] fr [5];
  wire logic [3:0] hnzc;
  wire logic [1:0] mask;
  int nMismatch = 0;
  int nTests = 0;
  assign hnzc = {conditionFlags[4], conditionFlags[2:0]};
  assign mask = {conditionFlags[5], conditionFlags[3]};
  always #10 clk = ~clk;

  cpu_core_register_set u_cpu_core_register_set (
    .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAluOp(cmdAluOp),
    .cmdReg(cmdReg), .cmdData(cmdData), .cmdAddr(cmdAddr), .cmdPriority(cmdPriority),
    .memRdData(memRdData), .busy(busy), .memAddr(memAddr), .memWrData(memWrData),
    .memWrite(memWrite), .memRead(memRead), .accumulator(accumulator), .indexFirst(indexFirst),
    .indexSecond(indexSecond), .programCounter(programCounter), .conditionFlags(conditionFlags),
    .stackPointer(stackPointer), .flashProgramControl(flashProgramControl)
  );
  crs_mem_model #(.RESET_VECTOR(VEC)) u_crs_mem_model (
    .clk(clk), .memAddr(memAddr), .memWrData(memWrData), .memWrite(memWrite),
    .memRead(memRead), .memRdData(memRdData)
  );

  task automatic results;
    $display("comparisons=%0d mismatches=%0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Strobe stays up so commands can follow back to back
  task automatic cmd(input crs_pkg::crs_cmd_t c, input crs_pkg::crs_slot_t r,
      input logic [7:0] d, input crs_pkg::crs_alu_t a = crs_pkg::ALU_ADD);
    cmdValid = 1'b1;
    cmdCode = c;
    cmdReg = r;
    cmdData = d;
    cmdAluOp = a;
    @(negedge clk);
  endtask

  task automatic settle;
    int k;
    cmdValid = 1'b0;
    k = 0;
    @(negedge clk);
    while (busy !== 1'b0 && k < 50) begin
      @(negedge clk);
      k++;
    end
    // Last pushed byte lands in memory one edge after busy falls
    @(negedge clk);
    if (k == 50) begin
      nMismatch++;
      results();
    end
  endtask

  initial begin
    repeat (5) @(negedge clk);
    check(conditionFlags, 8'he8);
    check(stackPointer, 16'h017f);
    check(flashProgramControl, 8'h00);
    rst_n = 1'b1;
    settle();
    check(programCounter, VEC);
    cmd(crs_pkg::CMD_LOAD, crs_pkg::SLOT_A, 8'h0f);
    for (int i = 0; i < 6; i++) begin
      cmd(crs_pkg::CMD_ALU, crs_pkg::SLOT_A, DS[i], OPS[i]);
      check(accumulator, EA[i]);
      check(hnzc, EF[i]);
    end
    for (int i = 0; i < 4; i++) begin
      cmd(CC_OPS[i], crs_pkg::SLOT_A, (i == 2) ? 8'h01 : 8'h00);
      check(conditionFlags[0], (i % 2 == 0) ? 1'b1 : 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      cmd(MK_OPS[i], crs_pkg::SLOT_A, 8'h00);
      check(mask, (i % 2 == 0) ? 2'b11 : 2'b10);
    end
    cmd(crs_pkg::CMD_ALU, crs_pkg::SLOT_A, 8'h81, crs_pkg::ALU_OR);
    check({accumulator, 4'h0, hnzc}, 16'h8104);
    cmd(crs_pkg::CMD_ALU, crs_pkg::SLOT_A, 8'h00, crs_pkg::ALU_RRC);
    check({accumulator, 4'h0, hnzc}, 16'h4001);
    cmd(crs_pkg::CMD_PC_INC, crs_pkg::SLOT_A, 8'h00);
    check(programCounter, VEC + 16'h0001);
    cmdAddr = 16'h4321;
    cmd(crs_pkg::CMD_PC_SET, crs_pkg::SLOT_A, 8'h00);
    cmd(crs_pkg::CMD_LOAD, crs_pkg::SLOT_X, 8'h5a);
    cmd(crs_pkg::CMD_LOAD, crs_pkg::SLOT_Y, 8'ha5);
    cmd(crs_pkg::CMD_LOAD, crs_pkg::SLOT_A, 8'h3c);
    check(programCounter, 16'h4321);
    check({indexFirst, indexSecond}, 16'h5aa5);
    cc0 = conditionFlags;
    cmdAddr = 16'h1200;
    cmdPriority = 2'b01;
    cmd(crs_pkg::CMD_INT, crs_pkg::SLOT_A, 8'h00);
    // Issued while busy, must leave no trace
    cmd(crs_pkg::CMD_LOAD, crs_pkg::SLOT_A, 8'h77);
    settle();
    check({programCounter, mask}, {16'h1200, 2'b01});
    check(stackPointer, 16'h017a);
    fr = '{8'h21, 8'h43, 8'h5a, 8'h3c, cc0};
    for (int i = 0; i < 5; i++) begin
      check(u_crs_mem_model.mem[16'h017f - i], fr[i]);
    end
    check(u_crs_mem_model.mem[16'h017a], 8'h7a);
    cmd(crs_pkg::CMD_LOAD, crs_pkg::SLOT_X, 8'h00);
    cmd(crs_pkg::CMD_LOAD, crs_pkg::SLOT_Y, 8'h11);
    cmd(crs_pkg::CMD_INTERRUPT_RETURN_INSTR, crs_pkg::SLOT_A, 8'h00);
    settle();
    check({accumulator, indexFirst}, 16'h3c5a);
    check(indexSecond, 8'h11);
    check(conditionFlags, cc0);
    check({programCounter, stackPointer}, {16'h4321, 16'h017f});
    cmdAddr = 16'h2468;
    cmd(crs_pkg::CMD_CALL, crs_pkg::SLOT_A, 8'h00);
    settle();
    check({programCounter, stackPointer}, {16'h2468, 16'h017d});
    check({u_crs_mem_model.mem[16'h017f], u_crs_mem_model.mem[16'h017e]}, 16'h2143);
    cmd(crs_pkg::CMD_RET, crs_pkg::SLOT_A, 8'h00);
    settle();
    check({programCounter, stackPointer}, {16'h4321, 16'h017f});
    cmd(crs_pkg::CMD_LOAD, crs_pkg::SLOT_CC, 8'h01);
    check({accumulator, conditionFlags}, {8'h3c, 8'hc1});
    cmd(crs_pkg::CMD_PUSH, crs_pkg::SLOT_A, 8'h00);
    settle();
    check(stackPointer, 16'h017e);
    cmd(crs_pkg::CMD_POP, crs_pkg::SLOT_CC, 8'h00);
    settle();
    check({conditionFlags, stackPointer}, {8'hfc, 16'h017f});
    cmd(crs_pkg::CMD_LOAD_SPL, crs_pkg::SLOT_A, 8'h00);
    check(stackPointer, 16'h0100);
    cmd(crs_pkg::CMD_PUSH, crs_pkg::SLOT_X, 8'h00);
    settle();
    check({stackPointer, u_crs_mem_model.mem[16'h0100]}, {16'h01ff, 8'h5a});
    cmd(crs_pkg::CMD_POP, crs_pkg::SLOT_Y, 8'h00);
    settle();
    check({stackPointer, indexSecond}, {16'h0100, 8'h5a});
    cmd(crs_pkg::CMD_RSP, crs_pkg::SLOT_A, 8'h00);
    cmd(crs_pkg::CMD_FLASH_WR, crs_pkg::SLOT_A, 8'ha5);
    check(stackPointer, 16'h017f);
    settle();
    check(flashProgramControl, 8'ha5);
    results();
  end
endmodule
`default_nettype wire
